// File: verification/fwsr_flash_model.sv
// Behavioural flash device answering the write-status controller
`timescale 1ns/1ps
module fwsr_flash_model #(
    parameter int OP_NS = 2000,
    parameter int PROT_NS = 400,
    parameter int WIN_NS = 1000
) (
    input wire logic [17:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    output logic [15:0] o_dq,
    output logic o_ready_busy_n
);
    logic run_q = 1'b0, ers_q = 1'b0, win_q = 1'b0, fail_q = 1'b0;
    logic bad_q = 1'b0, prot_q = 1'b0, tog_q = 1'b0, sec_q = 1'b0;
    logic [15:0] mem_q = 16'hffff, pdat_q = 16'h0000, hold_q = 16'h0000;
    logic [15:0] stat;
    logic [15:0] cur;
    longint win_at = 0;
    longint done_at = 0;
    logic wr_seen = 1'b0;
    wire logic wr_act = !i_ce_n && !i_we_n;
    wire logic rd_act = !i_ce_n && !i_oe_n;

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    // Status word while an algorithm runs, array data otherwise
    assign stat = {8'h00, ers_q ? 1'b0 : ~pdat_q[7], tog_q, fail_q, 1'b0, win_q, sec_q, 2'b00};
    assign cur = run_q ? stat : mem_q;
    assign o_dq = rd_act ? cur : ~hold_q; // Released bus shows no stale value
    assign o_ready_busy_n = !run_q;

    // Each read cycle ends by holding the word read, then the toggle bit flips while an algorithm runs, the sector toggle only during erase
    always @(negedge rd_act)
    begin
        hold_q = cur;
        if (run_q)
        begin
            tog_q = ~tog_q;
            sec_q = sec_q ^ ers_q;
        end
    end

    // ------------------------------------------------------------
    // Command side
    // ------------------------------------------------------------
    // Only a real strobe low phase arms a command, not the unknown-to-low step at power-up
    always @(posedge wr_act)
    begin
        wr_seen = 1'b1;
    end

    // Command taken when the write strobe or chip enable rises
    always @(negedge wr_act)
    begin
        if (wr_seen && !(run_q && win_q))
        begin
            if (i_dq == 16'h00f0)
            begin
                run_q = 1'b0;
                fail_q = 1'b0;
            end
            else
            begin
                run_q = 1'b1;
                ers_q = (i_dq == 16'h0030);
                win_q = 1'b0;
                fail_q = 1'b0;
                pdat_q = i_dq;
                prot_q = i_addr[17];
                bad_q = !ers_q && !prot_q && |(i_dq & ~mem_q);
                win_at = $time + WIN_NS;
                done_at = prot_q ? $time + PROT_NS : (ers_q ? win_at + OP_NS : $time + OP_NS);
            end
        end
        wr_seen = 1'b0;
    end

    // Internal algorithm progress
    always #1
    begin
        if (run_q && ers_q && $time >= win_at)
            win_q = 1'b1;
        if (run_q && $time >= done_at)
        begin
            if (bad_q)
                fail_q = 1'b1;
            else
            begin
                run_q = 1'b0;
                if (!prot_q)
                    mem_q = ers_q ? 16'hffff : pdat_q;
            end
        end
    end
endmodule

// File: verification/tb.sv
// Testbench driving the write-status controller against a flash model
`timescale 1ns/1ps
module tb
    import fwsr_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [17:0] f_addr;
    logic [15:0] f_dq_out, f_dq_in, m_dq;
    logic f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_rb_n, o_busy;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] s, a, b;

    // ------------------------------------------------------------
    // Design, flash model and shared data bus
    // ------------------------------------------------------------
    fwsr_host dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(f_addr),
        .o_flash_dq_out(f_dq_out), .o_flash_dq_oe(f_dq_oe), .i_flash_dq_in(f_dq_in),
        .o_flash_ce_n(f_ce_n), .o_flash_oe_n(f_oe_n), .o_flash_we_n(f_we_n),
        .i_flash_ready_busy_n(f_rb_n), .o_busy(o_busy));
    fwsr_flash_model #(.OP_NS(2000), .PROT_NS(400), .WIN_NS(1000)) flash (.i_addr(f_addr),
        .i_dq(f_dq_in), .i_ce_n(f_ce_n), .i_oe_n(f_oe_n), .i_we_n(f_we_n), .o_dq(m_dq),
        .o_ready_busy_n(f_rb_n));
    // Bus level seen by both parties
    assign f_dq_in = f_dq_oe ? f_dq_out : m_dq;

    // Clock
    initial
    begin
        forever #2 i_mclk = ~i_mclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_mclk);
    endtask

    // Bounded wait until the sequencer reports idle
    task automatic wait_idle;
        logic [31:0] v;
        int n = 0;
        @(posedge i_mclk);
        do
        begin
            rd(FWSR_OFF_STATUS, v);
            n++;
        end while (v[0] !== 1'b0 && n < 3000);
        if (n >= 3000)
        begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic cmd(input logic [17:0] fa, input logic [15:0] fd);
        wr(FWSR_OFF_ADDR, {14'h0, fa});
        wr(FWSR_OFF_WDATA, {16'h0, fd});
        wr(FWSR_OFF_CTRL, 32'h1 << FWSR_CTRL_WRITE);
        wait_idle();
    endtask

    task automatic sread(output logic [31:0] d);
        wr(FWSR_OFF_CTRL, 32'h1 << FWSR_CTRL_READ);
        wait_idle();
        rd(FWSR_OFF_RDATA, d);
    endtask

    // Toggle poll, then result field and device busy flag
    task automatic poll(input logic [31:0] res);
        wr(FWSR_OFF_CTRL, 32'h1 << FWSR_CTRL_POLL);
        wait_idle();
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h26, res);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h3f, 32'h0);
        rd(4'hf, s);
        check(s, 32'h0);
        cmd(18'h00010, 16'h0055);
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h20, 32'h20);
        sread(a);
        sread(b);
        check(a & 32'h00a0, 32'h0080);
        check((a ^ b) & 32'h0044, 32'h0040);
        poll(32'h2);
        sread(a);
        check(a & 32'hffff, 32'h0055);
        cmd(18'h00010, 16'h00aa);
        poll(32'h4);
        sread(a);
        check(a & 32'hffff, 32'h0055);
        cmd(18'h20010, 16'h0011);
        poll(32'h2);
        sread(a);
        check(a & 32'hffff, 32'h0055);
        cmd(18'h00010, 16'h0030);
        sread(a);
        sread(b);
        check(a & 32'h00a8, 32'h0);
        check((a ^ b) & 32'h0044, 32'h0044);
        cmd(18'h00010, 16'h0030);
        repeat (150) @(posedge i_mclk);
        sread(a);
        check(a & 32'h0008, 32'h0);
        repeat (150) @(posedge i_mclk);
        sread(a);
        check(a & 32'h0088, 32'h0008);
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h10, 32'h10);
        cmd(18'h00010, 16'h0000);
        poll(32'h2);
        sread(a);
        check(a & 32'hffff, 32'hffff);
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h40, 32'h0);
        check({31'h0, o_busy}, 32'h0);
        cmd(18'h20010, 16'h0030);
        poll(32'h2);
        repeat (12500) @(posedge i_mclk);
        rd(FWSR_OFF_STATUS, s);
        check(s & 32'h40, 32'h40);
        close_out();
    end

    // Watchdog
    initial
    begin
        repeat (30000) @(posedge i_mclk);
        bad_count++;
        close_out();
    end
endmodule

// File: verilog/fwsr_host.sv
// Host controller that drives flash bus cycles and polls write status
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fwsr_host
    import fwsr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [17:0] o_flash_addr,
    output logic [15:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    input wire logic [15:0] i_flash_dq_in,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n,
    input wire logic i_flash_ready_busy_n,
    output logic o_busy
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fwsr_state_e st;
        fwsr_state_e ret;
        logic [7:0] cnt;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [15:0] first;
        logic [1:0] result;
        logic toggle_done;
        logic [31:0] rdout;
        logic [17:0] fa;
        logic [15:0] fdo;
        logic oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic busy;
        logic [13:0] since_cmd;
    } fwsr_state_s;
    fwsr_state_s s_reg, s_next;
    logic [15:0] dq_sync;
    logic rb_sync;
    logic toggled;
    logic [13:0] win_cyc;
    assign win_cyc = 14'(FWSR_WINDOW_CYC - 1);

    // Flash data and ready/busy pass two flops before use
    fwsr_sync #(.W(16)) u_dq_sync (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_flash_dq_in), .o_sync(dq_sync));
    fwsr_sync #(.W(1)) u_rb_sync (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_flash_ready_busy_n),
        .o_sync(rb_sync));

    // Toggle compare between consecutive status reads
    assign toggled = (s_reg.rdata[FWSR_BIT_TOGGLE] != s_reg.first[FWSR_BIT_TOGGLE]);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.toggle_done = 1'b0;
        if (s_reg.since_cmd != win_cyc)
            s_next.since_cmd = s_reg.since_cmd + 14'h0001;
        // Register reads, answered the next cycle
        if (i_rd)
        begin
            case (i_addr)
                FWSR_OFF_ADDR: s_next.rdout = {14'h0000, s_reg.addr};
                FWSR_OFF_WDATA: s_next.rdout = {16'h0000, s_reg.wdata};
                FWSR_OFF_STATUS: s_next.rdout = {25'h0000000, s_reg.since_cmd == win_cyc, ~rb_sync,
                    s_reg.rdata[FWSR_BIT_WINDOW], s_reg.rdata[FWSR_BIT_FAIL], s_reg.result, s_reg.busy};
                FWSR_OFF_RDATA: s_next.rdout = {16'h0000, s_reg.rdata};
                default: s_next.rdout = 32'h00000000;
            endcase
        end
        else
            s_next.rdout = 32'h00000000;
        // Register writes, ignored while a sequence runs
        if (i_wr && !s_reg.busy)
        begin
            case (i_addr)
                FWSR_OFF_ADDR: s_next.addr = i_wdata[17:0];
                FWSR_OFF_WDATA: s_next.wdata = i_wdata[15:0];
                FWSR_OFF_CTRL:
                begin
                    if (i_wdata[FWSR_CTRL_WRITE])
                    begin
                        s_next.st = FWSR_WR_LOW;
                        s_next.ret = FWSR_FINAL;
                        s_next.since_cmd = 14'h0000;
                    end
                    else if (i_wdata[FWSR_CTRL_READ])
                    begin
                        s_next.st = FWSR_RD_LOW;
                        s_next.ret = FWSR_FINAL;
                    end
                    else if (i_wdata[FWSR_CTRL_POLL])
                    begin
                        s_next.st = FWSR_RD_LOW;
                        s_next.ret = FWSR_P_FIRST;
                        s_next.result = FWSR_RES_NONE;
                    end
                    else if (i_wdata[FWSR_CTRL_ABORT])
                    begin
                        s_next.wdata = 16'h00f0;
                        s_next.st = FWSR_WR_LOW;
                        s_next.ret = FWSR_FINAL;
                    end
                    if (i_wdata[3:0] != 4'h0)
                    begin
                        s_next.busy = 1'b1;
                        s_next.cnt = FWSR_STROBE_CYC;
                    end
                end
                default: ;
            endcase
        end
        // Bus sequencer
        case (s_reg.st)
            FWSR_IDLE: ;
            FWSR_WR_LOW:
            begin
                s_next.fa = s_reg.addr;
                s_next.fdo = s_reg.wdata;
                s_next.oe = 1'b1;
                s_next.ce_n = 1'b0;
                s_next.we_n = 1'b0;
                s_next.oe_n = 1'b1;
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00)
                begin
                    s_next.we_n = 1'b1;
                    s_next.ce_n = 1'b1;
                    s_next.cnt = FWSR_RECOV_CYC;
                    s_next.st = FWSR_WR_HIGH;
                end
            end
            FWSR_WR_HIGH:
            begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00)
                begin
                    s_next.oe = 1'b0;
                    s_next.st = s_reg.ret;
                end
            end
            FWSR_RD_LOW:
            begin
                // One read cycle gives one status sample
                s_next.fa = s_reg.addr;
                s_next.oe = 1'b0;
                s_next.ce_n = 1'b0;
                s_next.oe_n = 1'b0;
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00)
                begin
                    s_next.rdata = dq_sync;
                    s_next.ce_n = 1'b1;
                    s_next.oe_n = 1'b1;
                    s_next.cnt = FWSR_RECOV_CYC;
                    s_next.st = FWSR_RD_HIGH;
                end
            end
            FWSR_RD_HIGH:
            begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00)
                    s_next.st = s_reg.ret;
            end
            FWSR_P_FIRST:
            begin
                s_next.first = s_reg.rdata;
                s_next.cnt = FWSR_STROBE_CYC;
                s_next.st = FWSR_RD_LOW;
                s_next.ret = FWSR_P_SECOND;
            end
            FWSR_P_SECOND:
            begin
                if (!toggled)
                begin
                    s_next.result = FWSR_RES_OK;
                    s_next.toggle_done = 1'b1;
                    s_next.st = FWSR_FINAL;
                end
                else if (s_reg.rdata[FWSR_BIT_FAIL])
                begin
                    s_next.first = s_reg.rdata;
                    s_next.cnt = FWSR_STROBE_CYC;
                    s_next.st = FWSR_RD_LOW;
                    s_next.ret = FWSR_P_RECHK;
                end
                else
                begin
                    s_next.first = s_reg.rdata;
                    s_next.cnt = FWSR_STROBE_CYC;
                    s_next.st = FWSR_RD_LOW;
                    s_next.ret = FWSR_P_SECOND;
                end
            end
            FWSR_P_RECHK:
            begin
                if (!toggled)
                begin
                    s_next.result = FWSR_RES_OK;
                    s_next.toggle_done = 1'b1;
                    s_next.st = FWSR_FINAL;
                end
                else
                begin
                    s_next.result = FWSR_RES_FAIL;
                    s_next.st = FWSR_RESET_CMD;
                end
            end
            FWSR_RESET_CMD:
            begin
                // Failure: reset command returns device to array read
                s_next.wdata = 16'h00f0;
                s_next.cnt = FWSR_STROBE_CYC;
                s_next.st = FWSR_WR_LOW;
                s_next.ret = FWSR_FINAL;
            end
            FWSR_FINAL:
            begin
                s_next.busy = 1'b0;
                s_next.st = FWSR_IDLE;
            end
            default: s_next.st = FWSR_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_reg <= '0;
            s_reg.st <= FWSR_IDLE;
            s_reg.ret <= FWSR_IDLE;
            s_reg.addr <= FWSR_ADDR_RST;
            s_reg.wdata <= FWSR_DATA_RST;
            s_reg.ce_n <= 1'b1;
            s_reg.oe_n <= 1'b1;
            s_reg.we_n <= 1'b1;
            s_reg.since_cmd <= 14'h0000;
        end
        else
            s_reg <= s_next;
    end

    assign o_rdata = s_reg.rdout;
    assign o_flash_addr = s_reg.fa;
    assign o_flash_dq_out = s_reg.fdo;
    assign o_flash_dq_oe = s_reg.oe;
    assign o_flash_ce_n = s_reg.ce_n;
    assign o_flash_oe_n = s_reg.oe_n;
    assign o_flash_we_n = s_reg.we_n;
    assign o_busy = s_reg.busy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    AST_NO_RD_WR: assert property (!(!s_reg.we_n && !s_reg.oe_n)) else $error("read and write overlap");
    AST_DQ_OFF_RD: assert property (!s_reg.oe_n |-> !s_reg.oe) else $error("host drives dq during read");
    AST_OK_NO_TOG: assert property (s_reg.toggle_done |-> !toggled) else $error("ok while toggling");
    AST_FAIL_RST: assert property ($rose(s_reg.result == FWSR_RES_FAIL) |-> s_reg.st == FWSR_RESET_CMD)
        else $error("fail without reset");
    AST_RST_DATA: assert property (s_reg.st == FWSR_RESET_CMD |=> s_reg.wdata == 16'h00f0 && s_reg.st == FWSR_WR_LOW)
        else $error("reset command wrong");
    AST_RECHK: assert property (s_reg.st == FWSR_P_SECOND && toggled && s_reg.rdata[FWSR_BIT_FAIL]
        |=> s_reg.ret == FWSR_P_RECHK) else $error("no recheck");
    AST_RESTART: assert property (s_reg.st == FWSR_IDLE && s_next.ret == FWSR_P_FIRST |=> s_reg.result == FWSR_RES_NONE)
        else $error("poll not restarted");
    AST_WE_PULSE: assert property ($fell(s_reg.we_n) |-> !s_reg.we_n [*3]) else $error("short write pulse");
    AST_IDLE_PINS: assert property (s_reg.st == FWSR_IDLE |-> s_reg.we_n && s_reg.oe_n)
        else $error("strobe active in idle");
    COV_OK: cover property (s_reg.result == FWSR_RES_OK && s_reg.st == FWSR_FINAL);
    COV_FAIL: cover property (s_reg.st == FWSR_RESET_CMD);
    COV_WRITE: cover property ($rose(s_reg.we_n));
endmodule

// File: verilog/fwsr_pkg.sv
// Constants and types for the flash write-status polling controller
// Functional notes
// - Host reads poll or sector toggle bits only at a valid address.
// - After a timeout failure the host writes the reset command.
// - Host checks window bit around each extra erase unless spacing is under 50 us; the controller only reports it (status bit 4) and a 50 us flag (bit 6).
// - Host reads twice and compares the toggle bit; unchanged means done.
// - If still toggling with fail bit set, host re-tests; toggling means failure.
// - A host that breaks off polling restarts with a fresh double read.
package fwsr_pkg;
    // Data bus bit positions
    localparam int unsigned FWSR_BIT_POLL = 7;
    localparam int unsigned FWSR_BIT_TOGGLE = 6;
    localparam int unsigned FWSR_BIT_FAIL = 5;
    localparam int unsigned FWSR_BIT_WINDOW = 3;
    localparam int unsigned FWSR_BIT_SECTOR = 2;
    // Clock rate
    localparam int unsigned FWSR_CLK_MHZ = 250;
    // Bus cycle phases: strobes low, then recovery high (least times round up)
    localparam int unsigned FWSR_T_STROBE_NS = 80;
    localparam int unsigned FWSR_T_RECOV_NS = 40;
    localparam logic [7:0] FWSR_STROBE_CYC = 8'((FWSR_T_STROBE_NS * FWSR_CLK_MHZ + 999) / 1000);
    localparam logic [7:0] FWSR_RECOV_CYC = 8'((FWSR_T_RECOV_NS * FWSR_CLK_MHZ + 999) / 1000);
    // Host window used to time extra sector erase commands
    localparam int unsigned FWSR_T_WINDOW_US = 50;
    localparam int unsigned FWSR_WINDOW_CYC = FWSR_T_WINDOW_US * FWSR_CLK_MHZ;
    // Command register offsets (software side)
    localparam logic [3:0] FWSR_OFF_CTRL = 4'h0;
    localparam logic [3:0] FWSR_OFF_ADDR = 4'h1;
    localparam logic [3:0] FWSR_OFF_WDATA = 4'h2;
    localparam logic [3:0] FWSR_OFF_STATUS = 4'h3;
    localparam logic [3:0] FWSR_OFF_RDATA = 4'h4;
    // Control register fields
    localparam int unsigned FWSR_CTRL_WRITE = 0;
    localparam int unsigned FWSR_CTRL_READ = 1;
    localparam int unsigned FWSR_CTRL_POLL = 2;
    localparam int unsigned FWSR_CTRL_ABORT = 3;
    // Polling results
    localparam logic [1:0] FWSR_RES_NONE = 2'h0;
    localparam logic [1:0] FWSR_RES_OK = 2'h1;
    localparam logic [1:0] FWSR_RES_FAIL = 2'h2;
    // Reset values
    localparam logic [17:0] FWSR_ADDR_RST = 18'h00000;
    localparam logic [15:0] FWSR_DATA_RST = 16'h0000;
    // Sequencer states
    typedef enum logic [3:0] {
        FWSR_IDLE = 4'h0,
        FWSR_WR_LOW = 4'h1,
        FWSR_WR_HIGH = 4'h2,
        FWSR_RD_LOW = 4'h3,
        FWSR_RD_HIGH = 4'h4,
        FWSR_P_FIRST = 4'h5,
        FWSR_P_SECOND = 4'h6,
        FWSR_P_RECHK = 4'h7,
        FWSR_RESET_CMD = 4'h8,
        FWSR_FINAL = 4'h9
    } fwsr_state_e;
endpackage

// File: verilog/fwsr_sync.sv
// Two-stage synchroniser for pins from the flash
`timescale 1ns/1ps
module fwsr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    // Meta stage read only by the output stage
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_reg <= '1;
            o_sync <= '1;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule
